// [inc/rsi_pkg.sv]
package rsi_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] RSI_CTRL_OFS = 12'h000;
    localparam logic [11:0] RSI_STAT_OFS = 12'h004;
    localparam logic [11:0] RSI_WARN_OFS = 12'h008;
    localparam logic [11:0] RSI_CFG_OFS = 12'h00C;
    localparam logic [11:0] RSI_DIAG_OFS = 12'h010;

    // CTRL fields
    localparam int RSI_CTRL_STOP_REQ = 0;
    localparam int RSI_CTRL_INHIBIT = 1;
    localparam int RSI_CTRL_NOTIFY_EN = 2;
    localparam int RSI_CTRL_ERR_CLR = 3;
    // CFG fields
    localparam int RSI_CFG_WL_SEL = 0;
    localparam int RSI_CFG_LOAD = 1;
    // WARN fields
    localparam int RSI_WARN_SRAM = 0;
    localparam int RSI_WARN_BATT = 1;
    localparam int RSI_WARN_DATE = 2;

    localparam logic [31:0] RSI_CTRL_RST = 32'h0000_0000;
    localparam logic RSI_WL_EN_RST = 1'b1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int RSI_CLK_HZ = 100_000_000;
    localparam int RSI_INIT_S = 11;
    localparam longint RSI_INIT_CYC = longint'(RSI_INIT_S) * RSI_CLK_HZ;
    localparam int RSI_BLINK_MS = 250;
    localparam int RSI_BLINK_CYC = RSI_BLINK_MS * (RSI_CLK_HZ / 1000);
    localparam int RSI_FAST_MS = 50;
    localparam int RSI_FAST_CYC = RSI_FAST_MS * (RSI_CLK_HZ / 1000);
    localparam logic [3:0] RSI_PAIR_BLINKS = 4'h8;
    localparam int RSI_SWSTOP_INIT = 1;

    typedef enum logic [2:0]
    {
        RSI_ST_STOP = 3'b001,
        RSI_ST_RUN = 3'b010,
        RSI_ST_LOCK = 3'b100
    } rsi_mode_t;
endpackage : rsi_pkg

// [design/rsi_blink.sv]
// Blink source: free square wave, or a counted burst of pulses
module rsi_blink
#(
    parameter int HALF_CYC = 25_000_000,
    parameter int BURST_W = 4
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic burst_start,
    input wire logic [BURST_W-1:0] burst_len,
    output logic wave,
    output logic burst_out
);
    import rsi_pkg::*;

    initial
    begin
        if (HALF_CYC < 1) $error("HALF_CYC must be positive");
    end

    logic [31:0] cnt;
    logic [BURST_W:0] edges;

    // Half-period divider driving the wave
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt <= 32'h0000_0000;
            wave <= 1'b0;
        end
        else if (cnt >= 32'(HALF_CYC - 1))
        begin
            cnt <= 32'h0000_0000;
            wave <= !wave;
        end
        else
        begin
            cnt <= cnt + 32'h0000_0001;
        end
    end

    // Burst counts half periods: two per pulse, then stays off
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            edges <= '0;
            burst_out <= 1'b0;
        end
        else if (burst_start)
        begin
            edges <= {burst_len, 1'b0};
            burst_out <= 1'b1;
        end
        else if (edges != '0 && cnt >= 32'(HALF_CYC - 1))
        begin
            edges <= edges - 1'b1;
            burst_out <= (edges > 1) ? !burst_out : 1'b0;
        end
    end
endmodule : rsi_blink

// [design/rsi_top.sv]
// Contract
// - Diagnostics are sampled once per scan and folded into status
// - Power lamp steady on with good supply, off without power
// - Power lamp blinks in bus-powered low-power mode or weak supply
// - Run lamp on in run mode, off in stop mode
// - Run lamp blinks at most 11 s during analog module init
// - Fault lamp on for error, blinks for warning, else off
// - Error in run mode forces stop mode automatically
// - Stop mode forces every output off
// - Error in stop mode blocks run until cleared
// - Warnings never cause or block mode changes
// - Each warning readable as a control bit by the program
// - Warnings: lost memory, low battery, replacement date if enabled
// - Switch stop then run re-enters run if no error
// - Power-up with switch at stop starts in stop mode
// - Refused pairing request blinks wireless lamp 8 times fast
// - Wireless on at factory default, disabled by config at run entry
// - Config loaded in stop takes effect at next run entry
module rsi_top
#(
    parameter longint INIT_CYC = rsi_pkg::RSI_INIT_CYC,
    parameter int BLINK_CYC = rsi_pkg::RSI_BLINK_CYC,
    parameter int FAST_CYC = rsi_pkg::RSI_FAST_CYC,
    parameter int OUT_W = 8
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Switch, supply and diagnostic sources
    input wire logic run_switch,
    input wire logic scan_tick,
    input wire logic err_src,
    input wire logic supply_ok,
    input wire logic supply_present,
    input wire logic bus_power_only,
    input wire logic analog_present,
    input wire logic analog_ready,
    input wire logic sram_lost,
    input wire logic batt_low,
    input wire logic batt_date_passed,
    input wire logic pair_req,
    input wire logic [OUT_W-1:0] out_req,
    // Lamps and outputs
    output logic power_indicator,
    output logic run_indicator,
    output logic fault_indicator,
    output logic wireless_indicator,
    output logic wireless_en,
    output logic [OUT_W-1:0] outputs
);
    import rsi_pkg::*;

    initial
    begin
        if (OUT_W < 1 || OUT_W > 32) $error("OUT_W out of range");
        if (INIT_CYC < 1) $error("INIT_CYC must be positive");
    end

    // ************************************************************
    // State
    // ************************************************************
    rsi_mode_t mode;
    rsi_mode_t next_mode;
    logic err_act;
    logic [2:0] warn;
    logic stop_req;
    logic inhibit;
    logic notify_en;
    logic cfg_wl_sel;
    logic cfg_pend;
    logic sw_prev;
    logic started;
    logic [63:0] init_cnt;
    logic init_blink;
    logic init_fault;
    logic wave;
    logic burst;
    logic burst_start;
    logic pair_prev;
    logic wr;
    logic rd;
    logic err_clr;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign err_clr = wr && paddr == RSI_CTRL_OFS && pwdata[RSI_CTRL_ERR_CLR];

    // ************************************************************
    // Diagnostics
    // ************************************************************
    // Error latched per scan; a new error wins over software clear
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            err_act <= 1'b0;
        end
        else if (scan_tick && err_src)
            err_act <= 1'b1;
        else if (err_clr)
            err_act <= 1'b0;
    end

    // Warning bits refreshed once per scan
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            warn <= 3'h0;
        end
        else if (scan_tick)
        begin
            warn[RSI_WARN_SRAM] <= sram_lost;
            warn[RSI_WARN_BATT] <= batt_low;
            warn[RSI_WARN_DATE] <= batt_date_passed && notify_en;
        end
    end

    // ************************************************************
    // Mode machine
    // ************************************************************
    // Warnings are not consulted here at all
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            RSI_ST_STOP:
            begin
                if (err_act)
                    next_mode = RSI_ST_LOCK;
                else if (run_switch && (!sw_prev || !started) && !stop_req)
                    next_mode = RSI_ST_RUN;
            end
            RSI_ST_RUN:
            begin
                if (err_act)
                    next_mode = RSI_ST_LOCK;
                else if (!run_switch || stop_req)
                    next_mode = RSI_ST_STOP;
            end
            RSI_ST_LOCK:
            begin
                if (!err_act)
                    next_mode = RSI_ST_STOP;
            end
            default: next_mode = RSI_ST_STOP;
        endcase
    end

    // Mode register; power-up always in stop
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            mode <= RSI_ST_STOP;
        else
            mode <= next_mode;
    end

    // Switch history: first sample after reset is taken as the start level
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sw_prev <= 1'b1;
            started <= 1'b0;
        end
        else
        begin
            sw_prev <= run_switch;
            // Once run or stop has been seen, only a lever cycle restarts
            started <= started || !run_switch || mode == RSI_ST_RUN;
        end
    end

    // ************************************************************
    // Configuration
    // ************************************************************
    // Wireless enable moves from staged config only at run entry
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_wl_sel <= 1'b0;
            cfg_pend <= 1'b0;
            wireless_en <= RSI_WL_EN_RST;
        end
        else
        begin
            if (wr && paddr == RSI_CFG_OFS && pwdata[RSI_CFG_LOAD])
            begin
                cfg_wl_sel <= pwdata[RSI_CFG_WL_SEL];
                cfg_pend <= 1'b1;
            end
            else if (cfg_pend && mode != RSI_ST_RUN && next_mode == RSI_ST_RUN)
            begin
                wireless_en <= cfg_wl_sel;
                cfg_pend <= 1'b0;
            end
        end
    end

    // Control register bits
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stop_req <= RSI_CTRL_RST[RSI_CTRL_STOP_REQ];
            inhibit <= RSI_CTRL_RST[RSI_CTRL_INHIBIT];
            notify_en <= RSI_CTRL_RST[RSI_CTRL_NOTIFY_EN];
        end
        else if (wr && paddr == RSI_CTRL_OFS)
        begin
            stop_req <= pwdata[RSI_CTRL_STOP_REQ];
            inhibit <= pwdata[RSI_CTRL_INHIBIT];
            notify_en <= pwdata[RSI_CTRL_NOTIFY_EN];
        end
    end

    // ************************************************************
    // Indicators
    // ************************************************************
    rsi_blink #(
        .HALF_CYC(BLINK_CYC),
        .BURST_W(4)
    ) u_slow (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .burst_start(1'b0),
        .burst_len(4'h0),
        .wave(wave),
        .burst_out()
    );

    rsi_blink #(
        .HALF_CYC(FAST_CYC),
        .BURST_W(4)
    ) u_fast (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .burst_start(burst_start),
        .burst_len(RSI_PAIR_BLINKS),
        .wave(),
        .burst_out(burst)
    );

    // Refused pairing request starts the burst
    assign burst_start = pair_req && !pair_prev && (!wireless_en || inhibit);

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            pair_prev <= 1'b0;
        else
            pair_prev <= pair_req;
    end

    // Analog init window after power-up, bounded length
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            init_cnt <= 64'h0;
            init_blink <= 1'b0;
            init_fault <= 1'b0;
        end
        else if (analog_present && !analog_ready && !init_fault)
        begin
            init_blink <= 1'b1;
            if (init_cnt >= 64'(INIT_CYC - 1))
            begin
                init_fault <= 1'b1;
                init_blink <= 1'b0;
            end
            else
                init_cnt <= init_cnt + 64'h1;
        end
        else
            init_blink <= 1'b0;
    end

    // Lamp drivers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power_indicator <= 1'b0;
            run_indicator <= 1'b0;
            fault_indicator <= 1'b0;
            wireless_indicator <= 1'b0;
        end
        else
        begin
            // Off unpowered, blinking on weak or bus-only supply, else steady
            power_indicator <= (!supply_present && !bus_power_only) ? 1'b0
                : (bus_power_only || !supply_ok) ? wave : 1'b1;
            run_indicator <= init_blink ? wave : (mode == RSI_ST_RUN);
            // Error outranks warning
            fault_indicator <= (err_act || init_fault) ? 1'b1
                : (warn != 3'h0) ? wave : 1'b0;
            wireless_indicator <= burst;
        end
    end

    // Plant outputs: off whenever not running
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            outputs <= '0;
        else
            outputs <= (next_mode == RSI_ST_RUN) ? out_req : '0;
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    // Zero-wait reads; unmapped addresses answer with an error
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= 32'h0000_0000;
                unique case (paddr)
                    RSI_CTRL_OFS: prdata <= {29'h0, notify_en, inhibit, stop_req};
                    RSI_STAT_OFS: prdata <= {26'h0, init_fault, wireless_en, cfg_pend,
                        err_act, mode == RSI_ST_LOCK, mode == RSI_ST_RUN};
                    RSI_WARN_OFS: prdata <= {29'h0, warn};
                    RSI_CFG_OFS: prdata <= {31'h0, cfg_wl_sel};
                    RSI_DIAG_OFS: prdata <= {28'h0, batt_date_passed, batt_low,
                        sram_lost, err_src};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule : rsi_top

// [verif/rsi_top_props.sv]
// ****************************************
// Port checks for the run/stop status block
// ****************************************
module rsi_top_props
#(
    parameter int OUT_W = 8
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic supply_ok,
    input wire logic supply_present,
    input wire logic bus_power_only,
    input wire logic analog_present,
    input wire logic scan_tick,
    input wire logic err_src,
    input wire logic pair_req,
    input wire logic power_indicator,
    input wire logic run_indicator,
    input wire logic fault_indicator,
    input wire logic wireless_indicator,
    input wire logic wireless_en,
    input wire logic [OUT_W-1:0] outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    property p_apb_answer;
        psel && !penable |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no ready after setup");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_reset_state;
        $rose(arst_n) |-> wireless_en && !run_indicator && outputs == '0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state at reset");
    property p_power_off;
        (!supply_present && !bus_power_only) [*3] |-> !power_indicator;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power lamp lit unpowered");
    property p_power_on;
        (supply_present && supply_ok && !bus_power_only) [*3] |-> power_indicator;
    endproperty
    a_power_on: assert property (p_power_on) else $error("power lamp dark");
    property p_err_stop;
        scan_tick && err_src |-> ##3 !run_indicator && outputs == '0 && fault_indicator;
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("error did not stop");
    property p_outputs_run;
        !analog_present && outputs != '0 ##1 outputs != '0 |-> run_indicator;
    endproperty
    a_outputs_run: assert property (p_outputs_run) else $error("outputs on in stop");
    property p_pair_refused;
        $rose(pair_req) && !wireless_en |-> ##[1:6] wireless_indicator;
    endproperty
    a_pair_refused: assert property (p_pair_refused) else $error("no refusal flash");

    c_error: cover property (scan_tick && err_src);
    c_refuse: cover property ($rose(pair_req) && !wireless_en);
    c_slverr: cover property (pslverr);
endmodule : rsi_top_props

bind rsi_top rsi_top_props #(.OUT_W(OUT_W)) i_props
(
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .supply_ok(supply_ok), .supply_present(supply_present),
    .bus_power_only(bus_power_only), .scan_tick(scan_tick), .err_src(err_src),
    .analog_present(analog_present),
    .pair_req(pair_req), .power_indicator(power_indicator), .run_indicator(run_indicator),
    .fault_indicator(fault_indicator), .wireless_indicator(wireless_indicator),
    .wireless_en(wireless_en), .outputs(outputs)
);

// [verif/rsi_panel.sv]
// ****************************************
// Front panel: run/stop lever and lamp watcher
// ****************************************
module rsi_panel
(
    input wire logic sys_clk,
    input wire logic want_run,
    input wire logic slow,
    input wire logic wireless_indicator,
    output logic run_switch,
    output int blink_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] lag;
    logic lamp_q;

    // Lever rests in run position at power-up
    initial
    begin
        run_switch = 1'b1;
        lag = 3'h0;
        lamp_q = 1'b0;
        blink_count = 0;
    end

    // Move the lever, late for a slow hand, and count wireless flashes
    always @(posedge sys_clk)
    begin
        lag <= (want_run == run_switch) ? 3'h0 : lag + 3'h1;
        if (want_run != run_switch && (!slow || lag == 3'h4))
            run_switch <= want_run;
        lamp_q <= wireless_indicator;
        if (wireless_indicator && !lamp_q)
            blink_count <= blink_count + 1;
    end
endmodule : rsi_panel

// [verif/tb_run_stop_status_indicator.sv]
module tb_run_stop_status_indicator;
    timeunit 1ns;
    timeprecision 1ps;
    import rsi_pkg::*;
    localparam int INIT = 200;
    logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, run_switch, scan_tick;
    logic err_src, supply_ok, supply_present, bus_power_only, analog_present, analog_ready;
    logic sram_lost, batt_low, batt_date_passed, pair_req, want_run, slow, rerr, en;
    logic power_indicator, run_indicator, fault_indicator, wireless_indicator, wireless_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] out_req, outputs;
    logic [2:0] scan_cnt, w;
    logic [1:0] code;
    int bad_count, checks, seed, blinks, n;

    rsi_top #(.INIT_CYC(INIT), .BLINK_CYC(4), .FAST_CYC(2), .OUT_W(8)) i_dut
    (
        .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_switch(run_switch), .scan_tick(scan_tick), .err_src(err_src),
        .supply_ok(supply_ok), .supply_present(supply_present),
        .bus_power_only(bus_power_only), .analog_present(analog_present),
        .analog_ready(analog_ready), .sram_lost(sram_lost), .batt_low(batt_low),
        .batt_date_passed(batt_date_passed), .pair_req(pair_req), .out_req(out_req),
        .power_indicator(power_indicator), .run_indicator(run_indicator),
        .fault_indicator(fault_indicator), .wireless_indicator(wireless_indicator),
        .wireless_en(wireless_en), .outputs(outputs)
    );
    rsi_panel i_panel
    (
        .sys_clk(sys_clk), .want_run(want_run), .slow(slow),
        .wireless_indicator(wireless_indicator), .run_switch(run_switch), .blink_count(blinks)
    );

    // ****************************************
    // Clock, scan pulse and helpers
    // ****************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // One program scan every eight clocks
    always @(posedge sys_clk)
    begin
        scan_cnt <= scan_cnt + 3'h1;
        scan_tick <= (scan_cnt == 3'h0);
    end

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bus cycle: setup, then access held until ready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // Lever to stop and back to run
    task automatic flip();
        want_run <= 1'b0;
        cyc(10);
        want_run <= 1'b1;
        cyc(12);
    endtask : flip

    function automatic logic lamp(input int sel);
        return (sel == 0) ? power_indicator : (sel == 1) ? fault_indicator : run_indicator;
    endfunction : lamp

    // Lamp seen over 16 clocks: 0 off, 1 steady, 2 blinking
    task automatic lamp_code(input int sel);
        int t;
        logic q;
        t = 0;
        q = lamp(sel);
        repeat (16)
        begin
            @(posedge sys_clk);
            t += int'(lamp(sel) != q);
            q = lamp(sel);
        end
        code = (t > 0) ? 2'h2 : {1'b0, q};
    endtask : lamp_code

    function automatic logic [1:0] pwr_exp(input logic [2:0] s);
        if (s[0] || (s[2] && !s[1]))
            return 2'h2;
        return {1'b0, s[2]};
    endfunction : pwr_exp

    task automatic pair();
        n = blinks;
        pair_req <= 1'b1;
        cyc(50);
        pair_req <= 1'b0;
        cyc(2);
        chk(blinks - n, 8);
        chk(wireless_indicator, 1'b0);
    endtask : pair

    task automatic report_and_stop();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        seed = 32'h6C28;
        {psel, penable, pwrite, paddr, pwdata, scan_cnt, scan_tick} = '0;
        {err_src, analog_present, analog_ready, sram_lost, batt_low, batt_date_passed} = '0;
        {pair_req, slow, bus_power_only, out_req} = '0;
        {supply_ok, supply_present, want_run} = 3'h6;
        arst_n = 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        cyc(12);
        chk({run_indicator, wireless_en, outputs}, 10'h100);
        apb(1'b0, RSI_CTRL_OFS, 32'h0);
        chk(rd, RSI_CTRL_RST);
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rd, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            {supply_present, supply_ok, bus_power_only} <= 3'(i);
            cyc(3);
            lamp_code(0);
            chk(code, pwr_exp(3'(i)));
        end
        {supply_present, supply_ok, bus_power_only} <= 3'h6;
        $display("power lamp test done");
        flip();
        chk(run_indicator, 1'b1);
        repeat (4)
        begin
            out_req <= 8'($random(seed));
            cyc(3);
            chk(outputs, out_req);
        end
        apb(1'b1, RSI_CTRL_OFS, 32'h1 << RSI_CTRL_STOP_REQ);
        cyc(3);
        chk({run_indicator, outputs}, 9'h0);
        apb(1'b1, RSI_CTRL_OFS, 32'h0);
        cyc(3);
        chk(run_indicator, 1'b0);
        flip();
        $display("run stop test done");
        for (int i = 0; i < 6; i++)
        begin
            w = (i < 2) ? 3'h4 : 3'($random(seed));
            en = i[0];
            apb(1'b1, RSI_CTRL_OFS, 32'(en) << RSI_CTRL_NOTIFY_EN);
            {batt_date_passed, batt_low, sram_lost} <= w;
            cyc(20);
            apb(1'b0, RSI_WARN_OFS, 32'h0);
            chk(rd, {29'h0, w[2] & en, w[1:0]});
            lamp_code(1);
            chk(code, ({w[2] & en, w[1:0]} != 3'h0) ? 2'h2 : 2'h0);
            chk(run_indicator, 1'b1);
        end
        $display("warning test done");
        sram_lost <= 1'b1;
        out_req <= 8'hFF;
        cyc(20);
        err_src <= 1'b1;
        cyc(12);
        err_src <= 1'b0;
        cyc(4);
        chk({run_indicator, outputs}, 9'h0);
        lamp_code(1);
        chk(code, 2'h1);
        flip();
        chk(run_indicator, 1'b0);
        apb(1'b1, RSI_CTRL_OFS, 32'h1 << RSI_CTRL_ERR_CLR);
        flip();
        chk(run_indicator, 1'b1);
        $display("error test done");
        apb(1'b1, RSI_CTRL_OFS, 32'h1 << RSI_CTRL_INHIBIT);
        pair();
        apb(1'b1, RSI_CTRL_OFS, 32'h0);
        want_run <= 1'b0;
        cyc(10);
        apb(1'b1, RSI_CFG_OFS, 32'h1 << RSI_CFG_LOAD);
        cyc(4);
        chk(wireless_en, 1'b1);
        slow <= 1'b1;
        flip();
        chk(wireless_en, 1'b0);
        pair();
        $display("wireless test done");
        analog_present <= 1'b1;
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        lamp_code(2);
        chk(code, 2'h2);
        cyc(INIT + 20);
        chk(fault_indicator, 1'b1);
        $display("analog init test done");
        report_and_stop();
    end

    // Cut a hang short
    initial
    begin
        #50us;
        bad_count++;
        report_and_stop();
    end
endmodule : tb_run_stop_status_indicator
